// *** hdl/rss_consts.svh ***
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
// ==========================================================
// register map (word index = byte address)
`define RSS_ADDR_W 4
`define RSS_REG_POWER_CTRL 4'h0
`define RSS_REG_WD_CTRL 4'h1
`define RSS_REG_WDRESTART 4'h2
`define RSS_REG_SWRESET 4'h3
`define RSS_REG_STATUS 4'h4
// ==========================================================
// field positions and reset values
`define RSS_POWER_OFF_BIT 4
`define RSS_WD_OVF_BIT 0
`define RSS_WD_SWR_BIT 1
`define RSS_POWER_CTRL_RESET 8'h00
// ==========================================================
// key sequences
`define RSS_WD_KEY1 8'h1E
`define RSS_WD_KEY2 8'hE1
`define RSS_SW_KEY1 8'h5A
`define RSS_SW_KEY2 8'hA5
// ==========================================================
// timing
`define RSS_CLK_MHZ 200
`define RSS_T_POR_US 92
`define RSS_STARTUP_RC0_US 16
`define RSS_STARTUP_RC1_US 512
`define RSS_STARTUP_RC2_US 1024
`define RSS_STARTUP_RC3_US 4096
`define RSS_STARTUP_XT0_US 1024
`define RSS_STARTUP_XT1_US 2048
`define RSS_STARTUP_XT2_US 4096
`define RSS_STARTUP_XT3_US 16384
`define RSS_STARTUP_MAX_US 16384
`define RSS_PULSE_CYC 16
`define RSS_PIN_MIN_CYC 2
`define RSS_RESET_VECTOR 16'h0000
`endif

// *** hdl/rss_pkg.sv ***
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_OFF = 2'b00,
        RSS_INIT = 2'b01,
        RSS_WAIT = 2'b11,
        RSS_RUN = 2'b10
    } rss_state_t;
    typedef struct packed {
        logic por_low;
        logic brownout_low;
    } rss_supply_t;
    typedef struct packed {
        logic brownout_en;
        logic pin_en;
        logic crystal;
        logic [1:0] startup_time_fuses;
    } rss_fuse_t;
endpackage : rss_pkg

// *** hdl/rss_reset_sequencer.sv ***
// Operation
// R1: reset returns registers to defaults, tristates pins, starts at 0000H.
// R2: internal reset ORs power-on, brown-out, pin, watchdog and software sources.
// R3: after supply rises, run 92 us init, then start-up timer delay.
// R4: power-on reset reasserts immediately when supply drops below threshold.
// R5: power-on reset sets the power-off flag.
// R6: pin held low past power-up timeout keeps reset until it rises.
// R7: with brown-out enabled, timer waits for good supply and end of init.
// R8: two fuses plus clock source select start-up delay from table.
// R9: same delay applies after brown-out and internally timed wake-up.
// R10: brown-out asserts reset at once, releases after start-up delay.
// R11: brown-out acts only when its enable fuse is set.
// R12: fuse 1 makes shared pin reset input, else general-purpose I/O.
// R13: pin must be low two clocks to trigger reset.
// R14: during power-up the pin is always reset input.
// R15: only power-up overrides the pin fuse.
// R16: programming entry while pin low; fuse-off needs pin low at power-up.
// R17: watchdog timeout gives 16-clock reset and sets overflow flag.
// R18: software writes 1EH then E1H to restart watchdog in time.
// R19: writing 5AH then A5H gives 16-clock reset and sets software flag.
// R20: power-off flag software settable, untouched by warm resets.
// R21: reset output is OR of sources; short pulses never shorten others.
//
// The implementer's own choices: the register offsets and strobed register access.
`include "rss_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer
    import rss_pkg::*;
#(
    parameter int CLK_MHZ = `RSS_CLK_MHZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // supply monitor comparators, fuses and timed wake-up request
    input wire rss_supply_t supply,
    input wire rss_fuse_t fuses,
    input wire logic wake_timed,
    // watchdog counter
    input wire logic wd_timeout,
    // shared pin, five signals
    input wire logic shared_reset_gpio_in,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    output logic shared_reset_gpio_out,
    output logic shared_reset_gpio_oe,
    // register port
    input wire logic [`RSS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // results
    output logic internal_reset,
    output logic [15:0] start_vector,
    output logic wd_restart,
    output logic isp_enable,
    output logic power_off_flag,
    output logic watchdog_overflow_flag,
    output logic software_reset_flag,
    output logic pin_is_reset
);
    // ==========================================================
    // timing
    localparam int T_POR_CYC = `RSS_T_POR_US * CLK_MHZ;
    localparam int MAX_STARTUP_CYC = `RSS_STARTUP_MAX_US * CLK_MHZ;
    localparam int CW = $clog2(MAX_STARTUP_CYC + 1);

    // table kept in microseconds so one parameter rescales every delay
    function automatic logic [CW-1:0] startup_cycles(input rss_fuse_t f);
        int us;
        begin
            case ({f.crystal, f.startup_time_fuses}) // R8
                3'b000: us = `RSS_STARTUP_RC0_US;
                3'b001: us = `RSS_STARTUP_RC1_US;
                3'b010: us = `RSS_STARTUP_RC2_US;
                3'b011: us = `RSS_STARTUP_RC3_US;
                3'b100: us = `RSS_STARTUP_XT0_US;
                3'b101: us = `RSS_STARTUP_XT1_US;
                3'b110: us = `RSS_STARTUP_XT2_US;
                default: us = `RSS_STARTUP_XT3_US;
            endcase
            startup_cycles = CW'(us * CLK_MHZ);
        end
    endfunction : startup_cycles

    // one register-port write strobe aimed at one offset
    function automatic logic wr_hit(input logic wr, input logic [`RSS_ADDR_W-1:0] addr,
            input logic [`RSS_ADDR_W-1:0] target);
        begin
            wr_hit = wr && addr == target;
        end
    endfunction : wr_hit

    // ==========================================================
    // input synchronisers
    // fuses are static levels and skip the synchronisers
    logic [1:0] por_s, brown_s, pin_s, wake_s;
    always_ff @(posedge clock) begin
        por_s <= {por_s[0], supply.por_low};
        brown_s <= {brown_s[0], supply.brownout_low};
        pin_s <= {pin_s[0], shared_reset_gpio_in};
        wake_s <= {wake_s[0], wake_timed};
    end
    logic por_low, brownout_low, pin_high;
    assign por_low = por_s[1];
    assign brownout_low = brown_s[1] & fuses.brownout_en; // R11
    assign pin_high = pin_s[1];

    // ==========================================================
    // power-up sequence
    rss_state_t st_q;
    logic [CW-1:0] cnt_q;
    logic init_done_q;
    logic powerup_q;
    logic brown_q;
    always_ff @(posedge clock) begin
        if (rst || por_low) begin // R4
            st_q <= RSS_INIT;
            cnt_q <= '0;
            init_done_q <= 1'b0;
            powerup_q <= 1'b1;
            brown_q <= 1'b0;
        end else begin
            case (st_q)
                RSS_INIT: begin // R3
                    if (cnt_q == CW'(T_POR_CYC - 1)) begin
                        init_done_q <= 1'b1;
                        cnt_q <= '0;
                        st_q <= RSS_WAIT;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                RSS_WAIT: begin
                    if (brownout_low) begin // R7 R10
                        cnt_q <= '0;
                    end else if (cnt_q >= startup_cycles(fuses) - 1'b1) begin // R9
                        // a pin still low at the power-up time-out stretches the cold reset
                        if (!powerup_q || pin_high) begin // R6 R14
                            cnt_q <= '0;
                            st_q <= RSS_RUN;
                            powerup_q <= 1'b0;
                            brown_q <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                RSS_RUN: begin
                    if (brownout_low) begin // R10
                        brown_q <= 1'b1;
                        cnt_q <= '0;
                        st_q <= RSS_WAIT;
                    end else if (wake_s[1]) begin // R9
                        cnt_q <= '0;
                        st_q <= RSS_WAIT;
                    end
                end
                default: st_q <= RSS_INIT;
            endcase
        end
    end
    logic seq_busy;
    assign seq_busy = (st_q != RSS_RUN);

    // ==========================================================
    // shared pin function
    logic pin_active;
    assign pin_active = powerup_q | fuses.pin_en; // R12 R14 R15
    logic [1:0] low_cnt_q;
    logic pin_rst_q;
    always_ff @(posedge clock) begin
        if (rst || !pin_active || pin_high) begin
            low_cnt_q <= '0;
            pin_rst_q <= 1'b0;
        end else if (low_cnt_q >= 2'(`RSS_PIN_MIN_CYC - 1)) begin // R13 R6
            pin_rst_q <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 1'b1;
        end
    end
    // pin low sampled during power-up is the only route into programming when fuse is off
    logic isp_latch_q;
    always_ff @(posedge clock) begin
        if (rst || por_low) begin
            isp_latch_q <= 1'b0;
        end else if (powerup_q && !pin_high) begin
            isp_latch_q <= 1'b1;
        end else if (pin_high) begin
            isp_latch_q <= 1'b0;
        end
    end

    // ==========================================================
    // register writes and key sequences
    logic wd_key_q, sw_key_q;
    logic sw_req, wd_restart_d;
    always_comb begin
        sw_req = wr_hit(reg_wr, reg_addr, `RSS_REG_SWRESET) && sw_key_q
            && reg_wdata == `RSS_SW_KEY2; // R19
        wd_restart_d = wr_hit(reg_wr, reg_addr, `RSS_REG_WDRESTART) && wd_key_q
            && reg_wdata == `RSS_WD_KEY2; // R18
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            wd_key_q <= 1'b0;
            sw_key_q <= 1'b0;
        end else if (reg_wr) begin
            wd_key_q <= reg_addr == `RSS_REG_WDRESTART && reg_wdata == `RSS_WD_KEY1;
            sw_key_q <= reg_addr == `RSS_REG_SWRESET && reg_wdata == `RSS_SW_KEY1;
        end
    end

    // ==========================================================
    // 16-clock pulse from watchdog or software
    logic [4:0] pulse_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            pulse_q <= '0;
        end else if (wd_timeout || sw_req) begin // R17 R19
            // the request cycle itself is the first of the sixteen reset cycles
            pulse_q <= 5'(`RSS_PULSE_CYC - 1);
        end else if (pulse_q != '0) begin
            pulse_q <= pulse_q - 1'b1;
        end
    end

    // ==========================================================
    // cause flags: hardware set wins over software write
    logic power_off_q, ovf_q, swr_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            power_off_q <= 1'b0;
        end else if (por_low || st_q == RSS_INIT) begin // R5
            power_off_q <= 1'b1;
        end else if (wr_hit(reg_wr, reg_addr, `RSS_REG_POWER_CTRL)) begin // R20
            power_off_q <= reg_wdata[`RSS_POWER_OFF_BIT];
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            ovf_q <= 1'b0;
            swr_q <= 1'b0;
        end else begin
            if (wd_timeout) begin // R17
                ovf_q <= 1'b1;
            end else if (wr_hit(reg_wr, reg_addr, `RSS_REG_WD_CTRL)) begin
                ovf_q <= reg_wdata[`RSS_WD_OVF_BIT];
            end
            if (sw_req) begin // R19
                swr_q <= 1'b1;
            end else if (wr_hit(reg_wr, reg_addr, `RSS_REG_WD_CTRL)) begin
                swr_q <= reg_wdata[`RSS_WD_SWR_BIT];
            end
        end
    end

    // ==========================================================
    // reset combine and outputs
    logic rst_d;
    // requests feed in directly so a pulse starts in its own request cycle
    assign rst_d = seq_busy | por_low | brownout_low | pin_rst_q | (pulse_q != '0)
        | wd_timeout | sw_req; // R2 R21
    always_ff @(posedge clock) begin
        if (rst) begin
            internal_reset <= 1'b1;
            shared_reset_gpio_out <= 1'b0;
            shared_reset_gpio_oe <= 1'b0;
            start_vector <= `RSS_RESET_VECTOR;
            wd_restart <= 1'b0;
            isp_enable <= 1'b0;
            pin_is_reset <= 1'b1;
        end else begin
            internal_reset <= rst_d;
            start_vector <= `RSS_RESET_VECTOR; // R1
            shared_reset_gpio_out <= gpio_out;
            shared_reset_gpio_oe <= gpio_oe && !pin_active && !rst_d; // R1 R12
            wd_restart <= wd_restart_d;
            isp_enable <= (fuses.pin_en && !pin_high) || isp_latch_q; // R16
            pin_is_reset <= pin_active;
        end
    end
    assign power_off_flag = power_off_q;
    assign watchdog_overflow_flag = ovf_q;
    assign software_reset_flag = swr_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `RSS_REG_POWER_CTRL: reg_rdata <= 8'(power_off_q) << `RSS_POWER_OFF_BIT;
                `RSS_REG_WD_CTRL: reg_rdata <= {6'h00, swr_q, ovf_q};
                // status also tells whether the start-up delay under way follows a brown-out
                `RSS_REG_STATUS: reg_rdata <= {4'h0, brown_q, pin_active, st_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // helper: cycles since the last watchdog or software request
    logic [4:0] since_req_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            since_req_q <= 5'h1F;
        end else if (wd_timeout || sw_req) begin
            since_req_q <= '0;
        end else if (since_req_q != 5'h1F) begin
            since_req_q <= since_req_q + 1'b1;
        end
    end

    // ==========================================================
    // checks: supply and sequencer
    a_bod_immediate: assert property (@(posedge clock) disable iff (rst) // R10
        brownout_low |=> internal_reset) else $error("brown-out did not reset");
    a_por_immediate: assert property (@(posedge clock) disable iff (rst) // R4
        por_low |=> internal_reset) else $error("power loss did not reset");
    a_init_busy: assert property (@(posedge clock) disable iff (rst) // R3
        st_q == RSS_INIT |=> internal_reset) else $error("released during init");
    a_bod_wait: assert property (@(posedge clock) disable iff (rst) // R7 R10
        (st_q == RSS_WAIT && brownout_low && !por_low) |=> st_q == RSS_WAIT)
        else $error("start-up ran in low supply");
    a_powerup_hold: assert property (@(posedge clock) disable iff (rst) // R6 R14
        (powerup_q && !pin_high) |=> internal_reset) else $error("power-up ended with pin low");

    // ==========================================================
    // checks: watchdog and software pulses
    a_pulse_len: assert property (@(posedge clock) disable iff (rst) // R19
        $rose(sw_req) |=> internal_reset [*8]) else $error("pulse too short");
    a_wd_pulse: assert property (@(posedge clock) disable iff (rst) // R17
        wd_timeout |=> internal_reset [*8]) else $error("watchdog pulse too short");
    a_pulse_load: assert property (@(posedge clock) disable iff (rst) // R17 R19
        (wd_timeout || sw_req) |=> pulse_q == 5'(`RSS_PULSE_CYC - 1))
        else $error("pulse count not loaded");
    a_pulse_window: assert property (@(posedge clock) disable iff (rst) // R17 R19 R21
        since_req_q < 5'(`RSS_PULSE_CYC - 1) |=> internal_reset) else $error("pulse cut short");
    a_pulse_end: assert property (@(posedge clock) disable iff (rst) // R17 R19
        (since_req_q == 5'(`RSS_PULSE_CYC - 1) && !wd_timeout && !sw_req && !seq_busy
        && !por_low && !brownout_low && !pin_rst_q) |=> !internal_reset)
        else $error("pulse longer than sixteen cycles");
    a_wd_flag: assert property (@(posedge clock) disable iff (rst) // R17
        wd_timeout |=> watchdog_overflow_flag) else $error("overflow flag missing");
    a_sw_flag: assert property (@(posedge clock) disable iff (rst) // R19
        sw_req |=> software_reset_flag) else $error("software flag missing");

    // ==========================================================
    // checks: power-off flag
    a_pof_set: assert property (@(posedge clock) disable iff (rst) // R5
        por_low |=> power_off_flag) else $error("power-off flag missing");
    a_pof_keep: assert property (@(posedge clock) disable iff (rst) // R20
        (!por_low && st_q != RSS_INIT && !wr_hit(reg_wr, reg_addr, `RSS_REG_POWER_CTRL))
        |=> $stable(power_off_flag)) else $error("power-off flag changed by warm reset");

    // ==========================================================
    // checks: shared pin
    a_pin_held: assert property (@(posedge clock) disable iff (rst) // R6
        pin_rst_q |=> internal_reset) else $error("pin reset lost");
    a_pin_two: assert property (@(posedge clock) disable iff (rst) // R13
        (pin_active && !pin_high) [*3] |=> pin_rst_q) else $error("pin not caught");
    a_pin_fuse: assert property (@(posedge clock) disable iff (rst) // R12 R15
        !pin_active |=> !pin_rst_q) else $error("pin reset while pin is general-purpose");
    a_isp_pin: assert property (@(posedge clock) disable iff (rst) // R16
        (fuses.pin_en && !pin_high) |=> isp_enable) else $error("programming entry missed");
    a_gpio_off: assert property (@(posedge clock) disable iff (rst) // R1
        internal_reset |-> !shared_reset_gpio_oe) else $error("pin driven in reset");
    a_oe_reset: assert property (@(posedge clock) disable iff (rst) // R1
        rst_d |=> !shared_reset_gpio_oe) else $error("pin driven while reset pending");
    a_vector: assert property (@(posedge clock) disable iff (rst) // R1
        $fell(internal_reset) |-> start_vector == 16'h0000) else $error("bad vector");
endmodule : rss_reset_sequencer
`default_nettype wire

// *** tb/rss_pin_driver.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external reset circuit: open switch to ground with a pull-up
module rss_pin_driver (
    // request from the bench
    input wire logic press,
    // device side of the pin
    input wire logic dev_out,
    input wire logic dev_oe,
    // resolved pin level
    output logic pin
);
    // the bench keeps press up for two clocks or more when it means a reset
    always_comb begin
        if (dev_oe) begin
            pin = dev_out;
        end else begin
            pin = !press;
        end
    end
endmodule : rss_pin_driver
`default_nettype wire

// *** tb/rss_reset_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rss_reset_sequencer_tb_top;
    import rss_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    rss_supply_t supply = '0;
    rss_fuse_t fuses = 5'h08;
    logic wake_timed = 1'b0;
    logic wd_timeout = 1'b0;
    logic press = 1'b0;
    logic pin;
    logic gpio_out = 1'b0;
    logic gpio_oe = 1'b0;
    logic pin_out, pin_oe, wd_restart, isp_enable, power_off, wdovf, swr, pin_is_reset;
    logic internal_reset;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] start_vector;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    // start-up delays in cycles at one cycle per microsecond, {crystal, code}
    int startup_tab[8] = '{16, 512, 1024, 4096, 1024, 2048, 4096, 16384};
    always #2.5 clock = ~clock;
    rss_reset_sequencer #(.CLK_MHZ(1)) dut (.clock(clock), .rst(rst), .supply(supply),
        .fuses(fuses), .wake_timed(wake_timed), .wd_timeout(wd_timeout),
        .shared_reset_gpio_in(pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .shared_reset_gpio_out(pin_out), .shared_reset_gpio_oe(pin_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_reset(internal_reset), .start_vector(start_vector), .wd_restart(wd_restart),
        .isp_enable(isp_enable), .power_off_flag(power_off), .watchdog_overflow_flag(wdovf),
        .software_reset_flag(swr), .pin_is_reset(pin_is_reset));
    rss_pin_driver ext (.press(press), .dev_out(pin_out), .dev_oe(pin_oe), .pin(pin));
    // ==========================================================
    // shared tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cycles++;
        // all eight codes back to back plus margin; a hang ends the run as a failure
        if (cycles == 40000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        cyc(1);
        #1;
        check("read data", {8'h00, reg_rdata & mask}, {8'h00, exp});
    endtask : rd
    task automatic wait_rst(input logic lvl, input int max, output int n);
        #1;
        for (n = 0; n < max; n++) begin
            if (internal_reset === lvl) break;
            @(posedge clock);
            #1;
        end
    endtask : wait_rst
    task automatic pulse_len(input string what);
        int n;
        wait_rst(1'b1, 4, n);
        check(what, 16'(internal_reset), 16'h0001);
        wait_rst(1'b0, 40, n);
        check(what, 16'(n), 16'h0010);
    endtask : pulse_len
    task automatic idle_check(input string what, input int n);
        repeat (n) @(posedge clock);
        #1;
        check(what, 16'(internal_reset), 16'h0000);
    endtask : idle_check
    task automatic press_for(input int n);
        @(posedge clock);
        press <= 1'b1;
        repeat (n) @(posedge clock);
        press <= 1'b0;
    endtask : press_for
    // ==========================================================
    // scenarios
    task automatic t_powerup();
        int n;
        repeat (80) @(posedge clock);
        #1;
        check("reset in init", 16'(internal_reset), 16'h0001);
        check("pin released", 16'(pin_oe), 16'h0000);
        check("vector", start_vector, 16'h0000);
        check("power off flag", 16'(power_off), 16'h0001);
        wait_rst(1'b0, 60, n);
        check("start-up length", 16'(n >= 20 && internal_reset === 1'b0), 16'h0001);
        rd(4'hF, 8'hFF, 8'h00);
        @(posedge clock);
        wake_timed <= 1'b1;
        @(posedge clock);
        wake_timed <= 1'b0;
        wait_rst(1'b1, 6, n);
        check("wake reset", 16'(internal_reset), 16'h0001);
        wait_rst(1'b0, 40, n);
        check("wake delay", 16'(n >= 14 && n <= 20 && internal_reset === 1'b0), 16'h0001);
    endtask : t_powerup
    task automatic t_keys();
        int hits = 0;
        wr(4'h3, 8'h5A);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'hA5);
        cyc(1);
        idle_check("broken key", 6);
        wr(4'h3, 8'h5A);
        wr(4'h3, 8'hA5);
        cyc(1);
        pulse_len("software pulse");
        check("software flag", 16'(swr), 16'h0001);
        rd(4'h1, 8'h02, 8'h02);
        wr(4'h2, 8'h1E);
        wr(4'h2, 8'hE1);
        cyc(1);
        repeat (3) begin
            #1;
            hits += int'(wd_restart === 1'b1);
            @(posedge clock);
        end
        check("restart pulse", 16'(hits), 16'h0001);
        @(posedge clock);
        wd_timeout <= 1'b1;
        @(posedge clock);
        wd_timeout <= 1'b0;
        pulse_len("watchdog pulse");
        check("overflow flag", 16'(wdovf), 16'h0001);
        rd(4'h1, 8'h01, 8'h01);
    endtask : t_keys
    task automatic t_pin_bod();
        int n;
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h10, 8'h00);
        press_for(1);
        idle_check("short press", 6);
        press_for(4);
        @(posedge clock);
        #1;
        check("isp while low", 16'(isp_enable), 16'h0001);
        check("pin reset", 16'(internal_reset), 16'h0001);
        wait_rst(1'b0, 40, n);
        check("pin release", 16'(internal_reset), 16'h0000);
        @(posedge clock);
        supply.brownout_low <= 1'b1;
        idle_check("brown-out disabled", 10);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            fuses <= {1'b1, 1'b1, 3'(i)};
            wait_rst(1'b1, 6, n);
            check("brown-out reset", 16'(internal_reset), 16'h0001);
            @(posedge clock);
            supply.brownout_low <= 1'b0;
            wait_rst(1'b0, startup_tab[i] + 10, n);
            check("brown-out delay", 16'(n >= startup_tab[i] && n <= startup_tab[i] + 6),
                16'h0001);
            @(posedge clock);
            supply.brownout_low <= 1'b1;
        end
        @(posedge clock);
        supply.brownout_low <= 1'b0;
        fuses <= 5'h08;
        rd(4'h0, 8'h10, 8'h00);
    endtask : t_pin_bod
    task automatic t_por_gpio();
        int n;
        @(posedge clock);
        fuses.pin_en <= 1'b0;
        press <= 1'b1;
        supply.por_low <= 1'b1;
        wait_rst(1'b1, 6, n);
        check("por reset", 16'(internal_reset), 16'h0001);
        @(posedge clock);
        supply.por_low <= 1'b0;
        repeat (150) @(posedge clock);
        #1;
        check("held by pin", 16'(internal_reset), 16'h0001);
        check("isp at power-up", 16'(isp_enable), 16'h0001);
        check("cold flag", 16'(power_off), 16'h0001);
        @(posedge clock);
        press <= 1'b0;
        wait_rst(1'b0, 10, n);
        check("pin let go", 16'(internal_reset), 16'h0000);
        press_for(4);
        idle_check("pin as gpio", 4);
        check("pin role", 16'(pin_is_reset), 16'h0000);
        @(posedge clock);
        gpio_oe <= 1'b1;
        gpio_out <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check("gpio drive", {14'h0000, pin_oe, pin_out}, 16'h0003);
    endtask : t_por_gpio
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_powerup();
        t_keys();
        t_pin_bod();
        t_por_gpio();
        conclude();
    end
endmodule : rss_reset_sequencer_tb_top
`default_nettype wire
